// ===== design/dci_pkg.sv
// Purpose: constants for the converter control block
// Assumes: byte-wide special-function-register bus, core clock domain
// Notes:   control register address is a free choice of this design
package dci_pkg;

  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [7:0] DCI_ADDR_DATA_LOW  = 8'hfb;
  localparam logic [7:0] DCI_ADDR_DATA_HIGH = 8'hfc;
  localparam logic [7:0] DCI_ADDR_CONTROL   = 8'hfd;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] DCI_DATA_RESET     = 8'h00;
  localparam logic [4:0] DCI_CONTROL_RESET  = 5'h00;

  // ------------------------------------------------------------
  // control field positions
  // ------------------------------------------------------------
  localparam int DCI_BIT_ENABLE     = 0;
  localparam int DCI_BIT_CLEAR_N    = 1;
  localparam int DCI_BIT_RANGE      = 2;
  localparam int DCI_BIT_EIGHT_BIT  = 3;
  localparam int DCI_BIT_PIN_SELECT = 4;
  localparam int DCI_CONTROL_WIDTH  = 5;

  // ------------------------------------------------------------
  // code layout
  // ------------------------------------------------------------
  localparam int DCI_CODE_WIDTH     = 12;
  localparam int DCI_HIGH_NIBBLE    = 4;

endpackage

// ===== design/dci_code_format.sv
// Purpose: turns the two data bytes into a converter code
// Assumes: purely combinational, read by the main module's registers
// Notes:   eight-bit mode ignores the high byte completely
`timescale 1ns/100ps
module dci_code_format
  import dci_pkg::*;
(
  // data bytes
  input  wire logic [7:0]                data_low,
  input  wire logic [7:0]                data_high,
  // mode
  input  wire logic                      eight_bit_mode,
  // result
  output logic      [DCI_CODE_WIDTH-1:0] code
);

  always_comb begin
    if (eight_bit_mode) begin
      code = {data_low, 4'h0};
    end else begin
      code = {data_high[DCI_HIGH_NIBBLE-1:0], data_low};
    end
  end

endmodule

// ===== design/dci_control.sv
// Purpose: control and data registers of the 12-bit voltage-output converter
// Assumes: core writes with a one-cycle strobe; reads are combinational
// Notes:   analog string, buffer and pin routing live outside this logic
`timescale 1ns/100ps

module dci_control
  import dci_pkg::*;
(
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // special-function-register bus
  input  wire logic [7:0]                sfr_addr,
  input  wire logic                      sfr_wr,
  input  wire logic [7:0]                sfr_wdata,
  input  wire logic                      sfr_rd,
  output logic      [7:0]                sfr_rdata,
  output logic                           sfr_hit,
  // converter side
  output logic      [DCI_CODE_WIDTH-1:0] converter_code,
  output logic                           converter_enable,
  output logic                           output_hiz,
  output logic                           output_range_select,
  output logic                           output_pin_select,
  output logic                           code_update
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                   data_low;
    logic [7:0]                   data_high;
    logic [DCI_CONTROL_WIDTH-1:0] control;
    logic [DCI_CODE_WIDTH-1:0]    code;
    logic                         update;
  } dci_state_s;

  dci_state_s state_q;
  dci_state_s state_d;

  logic [DCI_CODE_WIDTH-1:0] next_code;
  logic [7:0]                low_next;
  logic [7:0]                high_next;
  logic [DCI_CONTROL_WIDTH-1:0] ctrl_next;
  logic                      wr_low;
  logic                      wr_high;
  logic                      wr_ctrl;

  assign wr_low  = sfr_wr && (sfr_addr == DCI_ADDR_DATA_LOW);
  assign wr_high = sfr_wr && (sfr_addr == DCI_ADDR_DATA_HIGH);
  assign wr_ctrl = sfr_wr && (sfr_addr == DCI_ADDR_CONTROL);

  // byte values the formatter sees after this cycle's write
  assign low_next  = wr_low  ? sfr_wdata : state_q.data_low;
  assign high_next = wr_high ? sfr_wdata : state_q.data_high;
  // mode taken from the control value of this cycle, without a loop through state_d
  assign ctrl_next = wr_ctrl ? sfr_wdata[DCI_CONTROL_WIDTH-1:0] : state_q.control;

  // ------------------------------------------------------------
  // code formatting
  // ------------------------------------------------------------
  dci_code_format u_format (
    .data_low       (low_next),
    .data_high      (high_next),
    .eight_bit_mode (ctrl_next[DCI_BIT_EIGHT_BIT]),
    .code           (next_code)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_d        = state_q;
    state_d.update = 1'b0;
    if (wr_ctrl) begin
      state_d.control = ctrl_next;
    end
    if (wr_high) begin
      state_d.data_high = sfr_wdata;
    end
    if (wr_low) begin
      state_d.data_low = sfr_wdata;
      state_d.code     = next_code;
      state_d.update   = 1'b1;
    end
    // clear held while bit is zero; wins over a data write
    if (!state_d.control[DCI_BIT_CLEAR_N]) begin
      state_d.data_low  = DCI_DATA_RESET;
      state_d.data_high = DCI_DATA_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q.data_low  <= DCI_DATA_RESET;
      state_q.data_high <= DCI_DATA_RESET;
      state_q.control   <= DCI_CONTROL_RESET;
      state_q.code      <= '0;
      state_q.update    <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // read side
  // ------------------------------------------------------------
  always_comb begin
    sfr_hit   = 1'b1;
    sfr_rdata = 8'h00;
    if (sfr_rd) begin
      unique case (sfr_addr)
        DCI_ADDR_DATA_LOW:  sfr_rdata = state_q.data_low;
        DCI_ADDR_DATA_HIGH: sfr_rdata = state_q.data_high;
        DCI_ADDR_CONTROL:   sfr_rdata = {3'h0, state_q.control};
        default:            sfr_hit   = 1'b0;
      endcase
    end else begin
      sfr_hit = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // converter outputs
  // ------------------------------------------------------------
  // the analog cell holds its code; the clear empties only the byte registers
  assign converter_code      = state_q.code;
  assign converter_enable    = state_q.control[DCI_BIT_ENABLE];
  assign output_hiz          = ~state_q.control[DCI_BIT_ENABLE];
  assign output_range_select = state_q.control[DCI_BIT_RANGE];
  assign output_pin_select   = state_q.control[DCI_BIT_PIN_SELECT];
  assign code_update         = state_q.update;

endmodule

// ===== tb/dci_control_monitor.sv
// Purpose: port checks of the converter control block
// Assumes: one register write per cycle
// Notes:   mode and clear bits mirrored from control writes
`timescale 1ns/100ps
module dci_control_monitor
  import dci_pkg::*;
(
  // clock and bus
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  // converter side
  input wire logic [11:0] converter_code,
  input wire logic        converter_enable,
  input wire logic        output_hiz,
  input wire logic        output_range_select,
  input wire logic        output_pin_select,
  input wire logic        code_update
);
  logic m8_q;
  logic clr_q;
  wire  wc = sfr_wr && sfr_addr == DCI_ADDR_CONTROL;
  wire  wh = sfr_wr && sfr_addr == DCI_ADDR_DATA_HIGH;
  wire  rdat = sfr_rd && (sfr_addr == DCI_ADDR_DATA_LOW || sfr_addr == DCI_ADDR_DATA_HIGH);
  always_ff @(posedge ref_clk) begin
    if (rst) {m8_q, clr_q} <= 2'b00;
    else if (wc) {m8_q, clr_q} <= {sfr_wdata[3], sfr_wdata[1]};
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence low_wr;
    sfr_wr && sfr_addr == DCI_ADDR_DATA_LOW;
  endsequence
  upd_pulse_a: assert property (low_wr ##1 !low_wr |-> code_update ##1 !code_update)
    else $error("code update pulse wrong");
  high_quiet_a: assert property (wh |=> !code_update)
    else $error("high write updated code");
  twelve_fmt_a: assert property (low_wr ##0 !m8_q
    |=> converter_code[7:0] == $past(sfr_wdata))
    else $error("twelve bit code wrong");
  eight_fmt_a: assert property (low_wr ##0 m8_q |=> converter_code == {$past(sfr_wdata), 4'h0})
    else $error("eight bit code wrong");
  code_hold_a: assert property (!code_update |-> $stable(converter_code))
    else $error("code moved without update");
  ctl_out_a: assert property (wc |=> converter_enable == $past(sfr_wdata[0])
    && output_hiz == !converter_enable && output_range_select == $past(sfr_wdata[2])
    && output_pin_select == $past(sfr_wdata[4]))
    else $error("control outputs wrong");
  reset_off_a: assert property ($fell(rst) |-> output_hiz && !converter_enable)
    else $error("converter on after reset");
  rsvd_zero_a: assert property (sfr_rd && sfr_addr == DCI_ADDR_CONTROL |-> sfr_rdata[7:5] == 3'h0)
    else $error("reserved bits not zero");
  clr_zero_a: assert property (rdat && !clr_q |-> sfr_rdata == 8'h00)
    else $error("data not cleared");
endmodule
bind dci_control dci_control_monitor u_mon (.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata,
  .sfr_rd, .sfr_rdata, .converter_code, .converter_enable, .output_hiz, .output_range_select,
  .output_pin_select, .code_update);

// ===== tb/dci_control_tb_top.sv
// Purpose: register level test of the converter control block
// Assumes: writes at least two cycles apart, reads sampled mid-cycle
// Notes:   control value table covers every control bit
`timescale 1ns/100ps
module dci_control_tb_top
  import dci_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic [11:0] code;
  logic        en, hiz, rng, pin, upd, hit;
  int          bad_count = 0;
  int          compares = 0;
  logic [7:0]  ctl [3] = '{8'h13, 8'hff, 8'h08};
  dci_control u_dut (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(hit),
    .converter_code(code), .converter_enable(en), .output_hiz(hiz),
    .output_range_select(rng), .output_pin_select(pin), .code_update(upd));
  initial forever #20 ref_clk = ~ref_clk;
  task automatic ck(string n, logic [11:0] e, logic [11:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(negedge ref_clk);
    ck("rdata", {4'h0, e}, {4'h0, sfr_rdata});
    ck("hit", {11'h0, a inside {DCI_ADDR_DATA_LOW, DCI_ADDR_DATA_HIGH, DCI_ADDR_CONTROL}},
      {11'h0, hit});
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    ck("off", 12'h001, {10'h0, en, hiz});
    rd(DCI_ADDR_DATA_LOW, 8'h00);
    rd(DCI_ADDR_DATA_HIGH, 8'h00);
    wr(DCI_ADDR_CONTROL, 8'h03);
    wr(DCI_ADDR_DATA_HIGH, 8'h0a);
    ck("code", 12'h000, code);
    wr(DCI_ADDR_DATA_LOW, 8'hbc);
    ck("upd", 12'habd, {code[11:1], upd});
    rd(DCI_ADDR_DATA_HIGH, 8'h0a);
    for (int i = 0; i < 3; i++) begin
      wr(DCI_ADDR_CONTROL, ctl[i]);
      ck("ctl", {8'h0, ctl[i][4], ctl[i][2], ctl[i][0], ~ctl[i][0]},
        {8'h0, pin, rng, en, hiz});
      rd(DCI_ADDR_CONTROL, {3'h0, ctl[i][4:0]});
    end
    rd(DCI_ADDR_DATA_HIGH, 8'h00);
    wr(DCI_ADDR_CONTROL, 8'h0a);
    wr(DCI_ADDR_DATA_HIGH, 8'h0f);
    wr(DCI_ADDR_DATA_LOW, 8'h5a);
    ck("code", 12'h5a0, code);
    rd(8'h10, 8'h00);
    print_verdict();
  end
  // hang guard, well past the roughly 50 cycles needed
  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end
endmodule
